// file: verilog/cimc_regs.vh
// Constants shared by the configurable I/O macrocell array
`ifndef CIMC_REGS_VH
`define CIMC_REGS_VH

// ==========================================================
// Array dimensions
`define CIMC_NCELL      10
`define CIMC_NDED       8
`define CIMC_NAIN       19
`define CIMC_NLIT       38
`define CIMC_NLOGIC     8
`define CIMC_NPT_CELL   9
`define CIMC_PT_OE      8
`define CIMC_PT_SET     90
`define CIMC_PT_CLR     91
`define CIMC_NGEN       42
`define CIMC_PT_GEN     92
`define CIMC_NTERM      134
`define CIMC_CFG_W      4
`define CIMC_CFG_ALL    40
`define CIMC_FUSE_W     5092
`define CIMC_ORF_W      420

// ==========================================================
// Array input positions
`define CIMC_AIN_FB     8
`define CIMC_AIN_CLK    18

// ==========================================================
// Cell configuration codes
`define CIMC_CFG_INPUT  4'h0
`define CIMC_CFG_1      4'h1
`define CIMC_CFG_2      4'h2
`define CIMC_CFG_3      4'h3
`define CIMC_CFG_4      4'h4
`define CIMC_CFG_5      4'h5
`define CIMC_CFG_6      4'h6
`define CIMC_CFG_7      4'h7
`define CIMC_CFG_8      4'h8
`define CIMC_CFG_9      4'h9
`define CIMC_CFG_10     4'hA
`define CIMC_CFG_11     4'hB
`define CIMC_CFG_12     4'hC

// ==========================================================
// Feedback source selects
`define CIMC_FB_PIN     2'h0
`define CIMC_FB_REG     2'h1
`define CIMC_FB_COMB    2'h2

// ==========================================================
// Reset values
`define CIMC_RST_1B     1'h0
`define CIMC_RST_CFG    40'h00_0000_0000
`define CIMC_RST_IN     19'h0_0000
`define CIMC_RST_CELL   10'h000

`endif

// file: verilog/cimc_and_array.v
// Programmable AND array forming all product terms
`include "cimc_regs.vh"

module cimc_and_array (
  input  wire [`CIMC_NLIT-1:0]   lits,
  input  wire [`CIMC_FUSE_W-1:0] fuse,
  output wire [`CIMC_NTERM-1:0]  terms
);

  genvar k;

  // ==========================================================
  // Product terms
  // Each term is true when every connected literal is true
  generate
    for (k = 0; k < `CIMC_NTERM; k = k + 1) begin : g_term
      assign terms[k] = &(lits | ~fuse[k*`CIMC_NLIT +: `CIMC_NLIT]);
    end
  endgenerate

endmodule

// file: verilog/cimc_cell.v
// One output macrocell: register, output mux and feedback mux
`include "cimc_regs.vh"

module cimc_cell (
  input  wire                   mclk,
  input  wire                   resetn,
  input  wire [`CIMC_CFG_W-1:0] cfg,
  input  wire                   sum,
  input  wire                   oe_term,
  input  wire                   clk_rise,
  input  wire                   set_term,
  input  wire                   clr_term,
  input  wire                   pin_in_s,
  output reg                    q_r,
  output reg                    pin_out_r,
  output reg                    pin_oe_r,
  output reg                    fb
);

  // Decode to {valid, registered pin, invert, feedback select}
  function [4:0] cimc_dec;
    input [`CIMC_CFG_W-1:0] c;
    begin
      case (c)
        `CIMC_CFG_1:  cimc_dec = {3'b110, `CIMC_FB_PIN};
        `CIMC_CFG_2:  cimc_dec = {3'b111, `CIMC_FB_PIN};
        `CIMC_CFG_3:  cimc_dec = {3'b110, `CIMC_FB_REG};
        `CIMC_CFG_4:  cimc_dec = {3'b111, `CIMC_FB_REG};
        `CIMC_CFG_5:  cimc_dec = {3'b110, `CIMC_FB_COMB};
        `CIMC_CFG_6:  cimc_dec = {3'b111, `CIMC_FB_COMB};
        `CIMC_CFG_7:  cimc_dec = {3'b100, `CIMC_FB_COMB};
        `CIMC_CFG_8:  cimc_dec = {3'b101, `CIMC_FB_COMB};
        `CIMC_CFG_9:  cimc_dec = {3'b100, `CIMC_FB_PIN};
        `CIMC_CFG_10: cimc_dec = {3'b101, `CIMC_FB_PIN};
        `CIMC_CFG_11: cimc_dec = {3'b100, `CIMC_FB_REG};
        `CIMC_CFG_12: cimc_dec = {3'b101, `CIMC_FB_REG};
        default:      cimc_dec = {3'b000, `CIMC_FB_PIN};
      endcase
    end
  endfunction

  wire [4:0] dec     = cimc_dec(cfg);
  wire       valid   = dec[4];
  wire       reg_out = dec[3];
  wire       invert  = dec[2];
  wire [1:0] fb_sel  = dec[1:0];

  reg        comb_r;
  wire       pin_val = reg_out ? q_r : sum;

  // ==========================================================
  // Cell register with global preset and clear
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_r <= `CIMC_RST_1B;
    end else if (clr_term) begin
      q_r <= 1'b0;
    end else if (clk_rise) begin
      q_r <= set_term ? 1'b1 : sum;
    end
  end

  // ==========================================================
  // Buried combinatorial node, held between array evaluations
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      comb_r <= `CIMC_RST_1B;
    end else begin
      comb_r <= sum;
    end
  end

  // ==========================================================
  // Pin driver, polarity and enable
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= `CIMC_RST_1B;
      pin_oe_r  <= `CIMC_RST_1B;
    end else begin
      pin_out_r <= pin_val ^ invert;
      pin_oe_r  <= valid & oe_term;
    end
  end

  // Feedback mux, independent of the pin enable
  always @* begin
    case (fb_sel)
      `CIMC_FB_REG:  fb = q_r;
      `CIMC_FB_COMB: fb = comb_r;
      default:       fb = pin_in_s;
    endcase
  end

endmodule

// file: verilog/cimc_top.v
// Top level of the configurable I/O macrocell logic array
`include "cimc_regs.vh"

// Functional notes
// - Every cell has one D register, a pin mux and a feedback mux.
// - Four configuration bits per cell pick one of twelve configurations.
// - Each pin is input, output or both; output is registered or not, high or low active.
// - Each cell has its own enable product term, for registered and plain outputs alike.
// - In the OR-array variant each enable is a sum of shared product terms.
// - The OR-array variant has 42 shared product terms serving 10 cells.
// - Configurations 3, 4, 9 and 10 act as classic registered or plain outputs.
// - Configurations 1 and 2 drive the register out and feed the pin back in.
// - Configurations 7 and 8 feed the sum back before the enable; pin shows it when enabled.
// - Configurations 5 and 6 feed the sum back while the pin shows the registered sum.
// - Configurations 11 and 12 feed the register back while the pin shows the sum.
// - One preset term acts at a clock edge and one clear term acts at once on all registers.
// - The device clock level is an input of the AND array.
// - Cell registers load on the rising device clock edge.
// - A buried-feedback cell can pass an input while clock is high and hold it while low.
module cimc_top (
  input  wire                     mclk,
  input  wire                     resetn,
  input  wire                     dev_clk,
  input  wire [`CIMC_NDED-1:0]    ded_in,
  input  wire [`CIMC_NCELL-1:0]   io_in,
  input  wire                     cfg_load,
  input  wire [`CIMC_CFG_ALL-1:0] cfg_word,
  input  wire                     cfg_or_variant,
  input  wire [`CIMC_FUSE_W-1:0]  and_fuse,
  input  wire [`CIMC_ORF_W-1:0]   or_fuse,
  output wire [`CIMC_NCELL-1:0]   io_out,
  output wire [`CIMC_NCELL-1:0]   io_oe,
  output wire [`CIMC_NCELL-1:0]   reg_state,
  output wire [`CIMC_CFG_ALL-1:0] cfg_state,
  output wire                     or_variant_state,
  output wire                     clk_level
);

  // ==========================================================
  // Declarations
  reg  [`CIMC_NAIN-1:0]   sync1_r;
  reg  [`CIMC_NAIN-1:0]   sync2_r;
  reg                     clk_prev_r;
  reg  [`CIMC_CFG_ALL-1:0] cfg_r;
  reg                     or_variant_r;
  reg                     clk_level_r;

  wire [`CIMC_NAIN-1:0]   raw_in;
  wire [`CIMC_NDED-1:0]   ded_s;
  wire [`CIMC_NCELL-1:0]  io_s;
  wire                    clk_s;
  wire                    clk_rise;
  wire [`CIMC_NCELL-1:0]  fb;
  wire [`CIMC_NAIN-1:0]   ain;
  wire [`CIMC_NLIT-1:0]   lits;
  wire [`CIMC_NTERM-1:0]  terms;
  wire [`CIMC_NGEN-1:0]   gen_terms;
  wire                    set_term;
  wire                    clr_term;
  wire [`CIMC_NCELL-1:0]  sums;
  wire [`CIMC_NCELL-1:0]  oe_and;
  wire [`CIMC_NCELL-1:0]  oe_or;
  wire [`CIMC_NCELL-1:0]  oe_sel;

  genvar c;

  // ==========================================================
  // Input synchronisers
  // All pins, the device clock included, come from outside mclk
  assign raw_in = {dev_clk, io_in, ded_in};

  // Two flip-flops deep; only the second stage is used further on
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= `CIMC_RST_IN;
      sync2_r <= `CIMC_RST_IN;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // Split the synchronised vector back into its groups
  assign ded_s = sync2_r[`CIMC_NDED-1:0];
  assign io_s  = sync2_r[`CIMC_AIN_CLK-1:`CIMC_AIN_FB];
  assign clk_s = sync2_r[`CIMC_AIN_CLK];

  // ==========================================================
  // Device clock edge detect
  // The device clock becomes a one-cycle load enable on mclk
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_prev_r <= `CIMC_RST_1B;
    end else begin
      clk_prev_r <= clk_s;
    end
  end

  assign clk_rise = clk_s & ~clk_prev_r;

  // Registered copy of the clock level for observation
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_level_r <= `CIMC_RST_1B;
    end else begin
      clk_level_r <= clk_s;
    end
  end

  // ==========================================================
  // Configuration store
  // Stands in for the nonvolatile cells; all cells start as inputs
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r        <= `CIMC_RST_CFG;
      or_variant_r <= `CIMC_RST_1B;
    end else if (cfg_load) begin
      cfg_r        <= cfg_word;
      or_variant_r <= cfg_or_variant;
    end
  end

  // ==========================================================
  // AND array inputs
  // Dedicated inputs, cell feedback and the clock level
  assign ain  = {clk_s, fb, ded_s};

  // True and complement of each array input
  assign lits = {~ain, ain};

  // All product terms, local and shared
  cimc_and_array u_and_array (
    .lits  (lits),
    .fuse  (and_fuse),
    .terms (terms)
  );

  // ==========================================================
  // Global terms
  // Preset is qualified by the clock edge inside the cells,
  // clear acts on the very next mclk edge
  assign set_term = terms[`CIMC_PT_SET];
  assign clr_term = terms[`CIMC_PT_CLR];

  // Shared pool of general product terms
  assign gen_terms = terms[`CIMC_PT_GEN +: `CIMC_NGEN];

  // ==========================================================
  // Per-cell sums and enables
  generate
    for (c = 0; c < `CIMC_NCELL; c = c + 1) begin : g_sum
      // Fixed OR of the cell's logic terms
      assign sums[c] = |terms[c*`CIMC_NPT_CELL +: `CIMC_NLOGIC];

      // Dedicated enable term of the cell
      assign oe_and[c] = terms[c*`CIMC_NPT_CELL + `CIMC_PT_OE];

      // Enable as a full sum of shared terms
      assign oe_or[c] = |(gen_terms & or_fuse[c*`CIMC_NGEN +: `CIMC_NGEN]);

      // Variant picks the enable source
      assign oe_sel[c] = or_variant_r ? oe_or[c] : oe_and[c];
    end
  endgenerate

  // ==========================================================
  // Macrocells
  generate
    for (c = 0; c < `CIMC_NCELL; c = c + 1) begin : g_cell
      cimc_cell u_cell (
        .mclk      (mclk),
        .resetn    (resetn),
        .cfg       (cfg_r[c*`CIMC_CFG_W +: `CIMC_CFG_W]),
        .sum       (sums[c]),
        .oe_term   (oe_sel[c]),
        .clk_rise  (clk_rise),
        .set_term  (set_term),
        .clr_term  (clr_term),
        .pin_in_s  (io_s[c]),
        .q_r       (reg_state[c]),
        .pin_out_r (io_out[c]),
        .pin_oe_r  (io_oe[c]),
        .fb        (fb[c])
      );
    end
  endgenerate

  // ==========================================================
  // Status outputs
  // All come straight from flip-flops
  assign cfg_state        = cfg_r;
  assign or_variant_state = or_variant_r;
  assign clk_level        = clk_level_r;

endmodule

// file: verification/cimc_top_props.sv
// Port-level assertions for the macrocell array top
`include "cimc_regs.vh"

module cimc_top_props (
  input wire                     mclk,
  input wire                     resetn,
  input wire                     dev_clk,
  input wire                     cfg_load,
  input wire [`CIMC_CFG_ALL-1:0] cfg_word,
  input wire                     cfg_or_variant,
  input wire [`CIMC_FUSE_W-1:0]  and_fuse,
  input wire [`CIMC_NCELL-1:0]   io_out,
  input wire [`CIMC_NCELL-1:0]   io_oe,
  input wire [`CIMC_NCELL-1:0]   reg_state,
  input wire [`CIMC_CFG_ALL-1:0] cfg_state,
  input wire                     or_variant_state,
  input wire                     clk_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mode code of cell 0
  wire [3:0] m0 = cfg_state[3:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Sequences
  sequence clk_hi; dev_clk [*5]; endsequence
  sequence clk_lo; !dev_clk [*5]; endsequence
  sequence clr_on; (and_fuse[3495:3458] == 38'h0) [*3]; endsequence
  // ==========================================================
  // Properties
  AST_CFG_LOAD: assert property (cfg_load |=> cfg_state == $past(cfg_word))
    else $error("config word not stored");
  AST_CFG_HOLD: assert property (!cfg_load |=> $stable(cfg_state))
    else $error("config changed without load");
  AST_VAR_LOAD: assert property (cfg_load |=> or_variant_state == $past(cfg_or_variant))
    else $error("variant not stored");
  AST_INPUT_ONLY: assert property ($past(m0) == 4'h0 || $past(m0) > 4'hC |-> !io_oe[0])
    else $error("input-only pin driven");
  AST_REG_PIN: assert property (m0 inside {[1:6]} && $stable(m0) && $stable(reg_state[0])
    |-> io_out[0] == (reg_state[0] ^ !m0[0])) else $error("registered pin wrong");
  AST_REG_CLK: assert property ($rose(reg_state[0]) |-> ##[0:2] clk_level)
    else $error("register rose without clock rise");
  AST_CLK_HI: assert property (clk_hi |-> clk_level)
    else $error("clock level not high");
  AST_CLK_LO: assert property (clk_lo |-> !clk_level)
    else $error("clock level not low");
  AST_CLR_ALL: assert property (clr_on |-> reg_state == 10'h000)
    else $error("clear term left a register set");
endmodule

bind cimc_top cimc_top_props u_props (.mclk(mclk), .resetn(resetn), .dev_clk(dev_clk),
  .cfg_load(cfg_load), .cfg_word(cfg_word), .cfg_or_variant(cfg_or_variant), .and_fuse(and_fuse),
  .io_out(io_out), .io_oe(io_oe), .reg_state(reg_state), .cfg_state(cfg_state),
  .or_variant_state(or_variant_state), .clk_level(clk_level));

// file: verification/cimc_pin_model.sv
// Board logic sharing the I/O wires with the device
module cimc_pin_model (
  input  wire        mclk,
  input  wire [9:0]  io_out,
  input  wire [9:0]  io_oe,
  input  wire [9:0]  ext_val,
  input  wire [9:0]  ext_en,
  output logic [9:0] io_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] float_r = 10'h155;
  // Undriven wires wander every cycle
  always @(posedge mclk) begin
    float_r <= ~float_r;
  end
  // Device driver first, board driver next, else floating
  always_comb begin
    io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_val) | (~io_oe & ~ext_en & float_r);
  end
endmodule

// file: verification/configurable_io_macrocell_bench.sv
// Self-checking bench for the macrocell array
`include "cimc_regs.vh"

module configurable_io_macrocell_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     mclk, resetn, dev_clk, cfg_load, cfg_or_variant;
  logic [7:0]               ded_in;
  logic [9:0]               io_in, io_out, io_oe, reg_state, ext_val, ext_en;
  logic [`CIMC_CFG_ALL-1:0] cfg_word, cfg_state;
  logic [`CIMC_FUSE_W-1:0]  and_fuse;
  logic [`CIMC_ORF_W-1:0]   or_fuse;
  logic                     or_variant_state, clk_level;
  int                       n_errors, n_tests, cyc;
  // Rows: mode, ded_in[0], expected enable, expected pin
  logic [6:0] rows [14] = '{7'h0F, 7'h16, 7'h1A, 7'h23, 7'h2F, 7'h36, 7'h3A,
                            7'h43, 7'h4F, 7'h56, 7'h5A, 7'h66, 7'h04, 7'h7C};

  cimc_top u_cimc_top (.mclk(mclk), .resetn(resetn), .dev_clk(dev_clk), .ded_in(ded_in),
    .io_in(io_in), .cfg_load(cfg_load), .cfg_word(cfg_word), .cfg_or_variant(cfg_or_variant),
    .and_fuse(and_fuse), .or_fuse(or_fuse), .io_out(io_out), .io_oe(io_oe), .reg_state(reg_state),
    .cfg_state(cfg_state), .or_variant_state(or_variant_state), .clk_level(clk_level));
  cimc_pin_model u_cimc_pin_model (.mclk(mclk), .io_out(io_out), .io_oe(io_oe),
    .ext_val(ext_val), .ext_en(ext_en), .io_in(io_in));

  // ==========================================================
  // Helpers
  // Never-true terms except always-true enables of cells 1-9, cell 0 sum is ded_in[0]
  function automatic logic [`CIMC_FUSE_W-1:0] fuses(input logic set, clr, en0, pool, fbk);
    logic [`CIMC_FUSE_W-1:0] f;
    f = '0;
    for (int k = 0; k < `CIMC_NTERM; k++) begin
      f[38*k+1] = 1'b1;
      f[38*k+20] = 1'b1;
    end
    f[37:0] = 38'h1;
    for (int c = 0; c < 10; c++) begin
      if (c > 0 || en0) f[38*(9*c+8) +: 38] = 38'h0;
    end
    if (set) f[3420 +: 38] = 38'h0;
    if (clr) f[3458 +: 38] = 38'h0;
    if (pool) f[3496 +: 38] = 38'h0;
    // Cell 1 sum follows the feedback of cell 0
    if (fbk) f[38*9 +: 38] = 38'h100;
    return f;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic load(input logic [7:0] m);
    cfg_word <= {32'h0, m};
    cfg_load <= 1'b1;
    tick(1);
    cfg_load <= 1'b0;
  endtask
  task automatic pulse();
    dev_clk <= 1'b1;
    tick(5);
    dev_clk <= 1'b0;
    tick(6);
  endtask
  task automatic check(input logic [9:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      $display("MISMATCH t=%0t run hung", $time);
      summarize();
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    resetn <= 1'b0; dev_clk <= 1'b0; cfg_load <= 1'b0; cfg_or_variant <= 1'b0;
    ded_in <= 8'h00; ext_val <= 10'h3FF; ext_en <= 10'h001; cfg_word <= '0;
    and_fuse <= fuses(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    or_fuse <= 420'h1;
    tick(5);
    check(io_oe, 10'h000, "reset enable");
    tick(1);
    resetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      ded_in[0] <= rows[i][2];
      load(rows[i][6:3]);
      pulse();
      check(10'(io_oe[0]), 10'(rows[i][1]), "mode enable");
      if (rows[i][1]) check(10'(io_out[0]), 10'(rows[i][0]), "mode pin");
    end
    $display("mode table done");
    and_fuse <= fuses(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    load(4'h9);
    tick(6);
    check(10'(io_oe[0]), 10'h000, "enable term false");
    cfg_or_variant <= 1'b1;
    and_fuse <= fuses(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    load(4'h9);
    tick(6);
    check(10'(io_oe[0]), 10'h000, "or enable empty");
    and_fuse <= fuses(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    tick(6);
    check(10'(io_oe[0]), 10'h001, "or enable set");
    cfg_or_variant <= 1'b0;
    $display("enable tests done");
    ded_in <= 8'h00;
    and_fuse <= fuses(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    tick(6);
    // Cell 0 still holds the one loaded by the last table row
    check(reg_state, 10'h001, "preset waits for clock");
    pulse();
    check(reg_state, 10'h3FF, "preset all");
    and_fuse <= fuses(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    tick(6);
    check(reg_state, 10'h000, "clear without clock");
    pulse();
    check(reg_state, 10'h000, "clear beats preset");
    $display("preset clear done");
    resetn <= 1'b0;
    tick(2);
    check(cfg_state[9:0], 10'h000, "mid-run reset");
    resetn <= 1'b1;
    tick(3);
    check(10'(or_variant_state), 10'h000, "variant after reset");
    $display("reset test done");
    // Cell 1 in mode 9 shows the feedback of cell 0; cell 0 pin is left to the board
    and_fuse <= fuses(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    load(8'h91);
    tick(6);
    check(10'(io_out[1]), 10'h001, "pin feedback");
    load(8'h97);
    tick(6);
    check(10'(io_out[1]), 10'h000, "buried sum feedback");
    ded_in[0] <= 1'b1;
    load(8'h9B);
    tick(6);
    check(10'(io_out[1]), 10'h000, "buried register feedback");
    pulse();
    check(10'(io_out[1]), 10'h001, "register feedback loaded");
    ded_in[0] <= 1'b0;
    load(8'h95);
    tick(6);
    check(10'(io_out[1]), 10'h000, "sum feedback with register");
    $display("feedback tests done");
    summarize();
  end
endmodule
